// >>> sch_chan_model.sv
// Behavioural buffered channel and process model facing the host controller
`timescale 1ns/1ps
module sch_chan_model
#(
    parameter int DEPTH = 4
)
(
    input  wire logic                        mclk,
    input  wire logic                        chanRst,
    input  wire logic                        slow,
    input  wire logic                        wrEn,
    input  wire logic                        wrEos,
    input  wire logic [sch_pkg::DATA_W-1:0]  wrData,
    output logic                             wrRdy,
    input  wire logic                        rdEn,
    output logic                             rdRdy,
    output logic                             rdEos,
    output logic [sch_pkg::DATA_W-1:0]       rdData,
    input  wire logic                        pinRdy,
    input  wire logic                        pinEos,
    input  wire logic [sch_pkg::DATA_W-1:0]  pinData,
    output logic                             pinEn,
    input  wire logic                        poutRdy,
    output logic                             poutEn,
    output logic                             poutEos,
    output logic [sch_pkg::DATA_W-1:0]       poutData
);
    logic [sch_pkg::DATA_W-1:0] fq[$];
    logic [sch_pkg::DATA_W-1:0] pq[$];
    logic [sch_pkg::DATA_W-1:0] tick;
    logic                       room;
    logic                       closed;
    logic                       pHave;
    logic                       srcDone;
    logic                       eosSent;

    // Ready only with room, stalls on request
    assign wrRdy  = room & ~closed & ~slow & ~chanRst;
    assign rdEos  = closed;
    assign pinEn  = pinRdy & ~slow;
    // Output enable only with a word or the closing mark
    assign poutEn = poutRdy & (pHave | (srcDone & ~eosSent));

    // One clock stands in for both domains
    always @(posedge mclk or posedge chanRst)
    begin
        if (chanRst)
        begin
            fq.delete();
            pq.delete();
            tick    <= 8'h00;
            {room, closed, pHave, srcDone, eosSent} <= 5'h00;
            {rdRdy, poutEos} <= 2'h0;
            rdData  <= 8'h00;
            poutData <= 8'h00;
        end
        else
        begin
            tick <= tick + 8'h01;
            if (rdEn && rdRdy)
                void'(fq.pop_front());
            if (wrEn && wrRdy && wrEos)
                closed <= 1'b1;
            else if (wrEn && wrRdy)
                fq.push_back(wrData);
            if (poutEn && pHave)
                void'(pq.pop_front());
            else if (poutEn)
                eosSent <= 1'b1;
            if (pinEn)
                pq.push_back(pinData);
            srcDone  <= srcDone | pinEos;
            room     <= fq.size() < DEPTH;
            rdRdy    <= fq.size() != 0;
            rdData   <= (fq.size() != 0) ? fq[0] : ~tick; // Idle lines keep moving
            pHave    <= pq.size() != 0;
            poutEos  <= pq.size() == 0;
            poutData <= (pq.size() != 0) ? pq[0] : tick;
        end
    end
endmodule // sch_chan_model

// >>> sch_host.sv
// Host controller driving the stream channel ports from outside
// Summary of operation
// - Writer holds end-of-stream and enable low before its first transfer.
// - Writer places data, raises enable, then waits for ready.
// - Writer drops enable after every transfer, even when another word follows.
// - Closing is an ordinary write with end-of-stream high; data ignored.
// - Stream closes on first ready edge of closing write; enable then drops.
// - Reader samples data before enable; word removed on next enable edge.
// - Reader lowers enable after every word, even when another word is wanted.
// - Direct source holds eos low, presents data, raises ready.
// - Source holds ready and data until an edge with process enable high.
// - Source without a word each cycle keeps ready low until data is set.
// - Direct source closes the process input by raising end-of-stream.
// - Direct sink raises ready and captures data and eos on enable edges.
// - Prefer the buffered channel; direct links keep the exact ordering.
`timescale 1ns/1ps
module sch_host
(
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    output logic                             chanRst,
    // Channel system-side write port
    output logic                             wrEn,
    output logic                             wrEos,
    output logic [sch_pkg::DATA_W-1:0]       wrData,
    input  wire logic                        wrRdy,
    // Channel system-side read port
    output logic                             rdEn,
    input  wire logic                        rdRdy,
    input  wire logic                        rdEos,
    input  wire logic [sch_pkg::DATA_W-1:0]  rdData,
    // Process input port, driven directly
    output logic                             pinRdy,
    output logic                             pinEos,
    output logic [sch_pkg::DATA_W-1:0]       pinData,
    input  wire logic                        pinEn,
    // Process output port, sunk directly
    output logic                             poutRdy,
    input  wire logic                        poutEn,
    input  wire logic                        poutEos,
    input  wire logic [sch_pkg::DATA_W-1:0]  poutData,
    // User side of the writer
    input  wire logic                        usrWrGo,
    input  wire logic                        usrWrClose,
    input  wire logic [sch_pkg::DATA_W-1:0]  usrWrData,
    output logic                             usrWrIdle,
    output logic                             usrWrDone,
    // User side of the reader
    input  wire logic                        usrRdWant,
    output logic                             usrRdValid,
    output logic [sch_pkg::DATA_W-1:0]       usrRdData,
    output logic                             usrRdClosed,
    // User side of the direct source
    input  wire logic                        usrSrcGo,
    input  wire logic                        usrSrcClose,
    input  wire logic [sch_pkg::DATA_W-1:0]  usrSrcData,
    output logic                             usrSrcIdle,
    // User side of the direct sink
    input  wire logic                        usrSnkEnable,
    output logic                             usrSnkValid,
    output logic                             usrSnkEos,
    output logic [sch_pkg::DATA_W-1:0]       usrSnkData
);
    // ****************************************
    // Channel reset
    // ****************************************
    logic chanRst_q;

    // channel held in reset with host
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            chanRst_q <= sch_pkg::RST_CHAN;
        else
            chanRst_q <= 1'b0;
    end
    assign chanRst = chanRst_q;

    // ****************************************
    // Writer engine
    // ****************************************
    sch_pkg::sch_wr_state_t     wrSt_q, wrSt_d;
    logic                       wrEn_q, wrEn_d;
    logic                       wrEos_q, wrEos_d;
    logic [sch_pkg::DATA_W-1:0] wrData_q, wrData_d;
    logic                       wrDone_q, wrDone_d;
    logic                       wrIdle_q, wrIdle_d;
    logic                       wrStarted_q;

    // Next state of the write handshake
    always_comb
    begin
        wrSt_d   = wrSt_q;
        wrEn_d   = wrEn_q;
        wrEos_d  = wrEos_q;
        wrData_d = wrData_q;
        wrDone_d = 1'b0;
        unique case (wrSt_q)
            sch_pkg::SCH_W_IDLE:
            begin
                if (usrWrGo && !chanRst_q)
                begin
                    if (!usrWrClose)
                        wrData_d = usrWrData;
                    wrEos_d = usrWrClose;
                    wrEn_d  = 1'b1;
                    wrSt_d  = sch_pkg::SCH_W_SEND;
                end
            end
            sch_pkg::SCH_W_SEND:
            begin
                if (wrRdy)
                begin
                    wrEn_d   = 1'b0;
                    wrDone_d = 1'b1;
                    wrSt_d   = wrEos_q ? sch_pkg::SCH_W_CLOSED : sch_pkg::SCH_W_IDLE;
                end
            end
            sch_pkg::SCH_W_CLOSED:
            begin
                wrEn_d = 1'b0;
            end
        endcase
        wrIdle_d = (wrSt_d == sch_pkg::SCH_W_IDLE);
    end

    // Registers of the write handshake
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrSt_q      <= sch_pkg::SCH_W_IDLE;
            wrEn_q      <= sch_pkg::RST_EN;
            wrEos_q     <= sch_pkg::RST_EOS;
            wrData_q    <= sch_pkg::RST_DATA;
            wrDone_q    <= 1'b0;
            wrIdle_q    <= 1'b0;
            wrStarted_q <= 1'b0;
        end
        else
        begin
            wrSt_q      <= wrSt_d;
            wrEn_q      <= wrEn_d;
            wrEos_q     <= wrEos_d;
            wrData_q    <= wrData_d;
            wrDone_q    <= wrDone_d;
            wrIdle_q    <= wrIdle_d;
            wrStarted_q <= wrStarted_q | wrEn_d;
        end
    end

    assign wrEn      = wrEn_q;
    assign wrEos     = wrEos_q;
    assign wrData    = wrData_q;
    assign usrWrIdle = wrIdle_q;
    assign usrWrDone = wrDone_q;

    a_wr_init_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
        !wrStarted_q |-> !wrEn_q && !wrEos_q)
        else $error("write lines active before first transfer");
    a_wr_hold_word: assert property (@(posedge mclk) disable iff (!rst_b)
        wrEn_q && !wrRdy |=> wrEn_q && $stable(wrData_q) && $stable(wrEos_q))
        else $error("write word changed before ready");
    a_wr_drop_en: assert property (@(posedge mclk) disable iff (!rst_b)
        wrEn_q && wrRdy |=> !wrEn_q ##1 wrDone_q == 1'b0)
        else $error("write enable kept after transfer");
    a_wr_close_end: assert property (@(posedge mclk) disable iff (!rst_b)
        wrEn_q && wrEos_q && wrRdy |=> (!wrEn_q && wrEos_q)[*4])
        else $error("writer active after closing write");

    // ****************************************
    // Reader engine
    // ****************************************
    // reader relies on ready marking data
    sch_reader u_reader
    (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .rdRdy     (rdRdy),
        .rdEos     (rdEos),
        .rdData    (rdData),
        .rdEn      (rdEn),
        .usrWant   (usrRdWant),
        .usrValid  (usrRdValid),
        .usrData   (usrRdData),
        .usrClosed (usrRdClosed)
    );

    // ****************************************
    // Direct source to process input
    // ****************************************
    logic                       pinRdy_q, pinRdy_d;
    logic                       pinEos_q, pinEos_d;
    logic [sch_pkg::DATA_W-1:0] pinData_q, pinData_d;
    logic                       srcIdle_q, srcIdle_d;

    // direct link ordering kept
    // Next values of the direct source
    always_comb
    begin
        pinRdy_d  = pinRdy_q;
        pinEos_d  = pinEos_q;
        pinData_d = pinData_q;
        if (pinRdy_q && pinEn)
            pinRdy_d = 1'b0;
        // ready only with data in place
        if (!pinRdy_d && !pinEos_q && !chanRst_q)
        begin
            if (usrSrcClose)
                pinEos_d = 1'b1;
            else if (usrSrcGo)
            begin
                pinData_d = usrSrcData;
                pinRdy_d  = 1'b1;
            end
        end
        // Source can take a command when nothing is offered or closed
        srcIdle_d = !pinRdy_d && !pinEos_d;
    end

    // Registers of the direct source
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinRdy_q  <= sch_pkg::RST_RDY;
            pinEos_q  <= sch_pkg::RST_EOS;
            pinData_q <= sch_pkg::RST_DATA;
            srcIdle_q <= 1'b1;
        end
        else
        begin
            pinRdy_q  <= pinRdy_d;
            pinEos_q  <= pinEos_d;
            pinData_q <= pinData_d;
            srcIdle_q <= srcIdle_d;
        end
    end

    assign pinRdy     = pinRdy_q;
    assign pinEos     = pinEos_q;
    assign pinData    = pinData_q;
    assign usrSrcIdle = srcIdle_q;

    a_src_eos_low: assert property (@(posedge mclk) disable iff (!rst_b)
        pinRdy_q |-> !pinEos_q)
        else $error("source eos high while offering data");
    a_src_hold_word: assert property (@(posedge mclk) disable iff (!rst_b)
        pinRdy_q && !pinEn |=> pinRdy_q && $stable(pinData_q))
        else $error("source offer changed before enable");
    // ready stays only with new word
    a_src_drop_rdy: assert property (@(posedge mclk) disable iff (!rst_b)
        pinRdy_q && pinEn |=> pinRdy_q == $past(usrSrcGo && !usrSrcClose))
        else $error("source ready kept after take without a new word");

    // ****************************************
    // Direct sink from process output
    // ****************************************
    logic                       poutRdy_q;
    logic                       snkValid_q, snkValid_d;
    logic                       snkEos_q, snkEos_d;
    logic [sch_pkg::DATA_W-1:0] snkData_q, snkData_d;

    // Next values of the direct sink
    always_comb
    begin
        snkValid_d = 1'b0;
        snkEos_d   = snkEos_q;
        snkData_d  = snkData_q;
        // capture data and eos on enable
        if (poutRdy_q && poutEn)
        begin
            snkValid_d = 1'b1;
            snkEos_d   = poutEos;
            snkData_d  = poutData;
        end
    end

    // Registers of the direct sink; one clock for all ports
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            poutRdy_q  <= sch_pkg::RST_RDY;
            snkValid_q <= 1'b0;
            snkEos_q   <= sch_pkg::RST_EOS;
            snkData_q  <= sch_pkg::RST_DATA;
        end
        else
        begin
            poutRdy_q  <= usrSnkEnable;
            snkValid_q <= snkValid_d;
            snkEos_q   <= snkEos_d;
            snkData_q  <= snkData_d;
        end
    end

    assign poutRdy     = poutRdy_q;
    assign usrSnkValid = snkValid_q;
    assign usrSnkEos   = snkEos_q;
    assign usrSnkData  = snkData_q;

    a_snk_capture: assert property (@(posedge mclk) disable iff (!rst_b)
        poutRdy_q && poutEn |=> snkValid_q && snkData_q == $past(poutData))
        else $error("sink missed a word");
endmodule // sch_host

// >>> sch_pkg.sv
// Constants shared by the stream channel host controller
package sch_pkg;
    // Word width of the stream data lines
    localparam int unsigned DATA_W = 8;
    // Reset values of the driven lines
    localparam logic RST_EN   = 1'b0;
    localparam logic RST_EOS  = 1'b0;
    localparam logic RST_RDY  = 1'b0;
    localparam logic RST_CHAN = 1'b1;
    localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
    // Writer engine states
    typedef enum logic [1:0] {
        SCH_W_IDLE,
        SCH_W_SEND,
        SCH_W_CLOSED
    } sch_wr_state_t;
endpackage

// >>> sch_reader.sv
// Reader engine for the channel's system-side read port
`timescale 1ns/1ps
module sch_reader
(
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    input  wire logic                        rdRdy,
    input  wire logic                        rdEos,
    input  wire logic [sch_pkg::DATA_W-1:0]  rdData,
    output logic                             rdEn,
    input  wire logic                        usrWant,
    output logic                             usrValid,
    output logic [sch_pkg::DATA_W-1:0]       usrData,
    output logic                             usrClosed
);
    logic                       en_q, en_d;
    logic                       valid_q, valid_d;
    logic [sch_pkg::DATA_W-1:0] data_q, data_d;
    logic                       closed_q, closed_d;

    // Next values of the read handshake
    always_comb
    begin
        en_d     = 1'b0;
        valid_d  = 1'b0;
        data_d   = data_q;
        closed_d = closed_q;
        if (!en_q && rdRdy && usrWant)
        begin
            data_d  = rdData;
            valid_d = 1'b1;
            en_d    = 1'b1;
        end
        if (rdEos && !rdRdy)
        begin
            closed_d = 1'b1;
        end
    end

    // Registers of the read handshake
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_q     <= sch_pkg::RST_EN;
            valid_q  <= 1'b0;
            data_q   <= sch_pkg::RST_DATA;
            closed_q <= 1'b0;
        end
        else
        begin
            en_q     <= en_d;
            valid_q  <= valid_d;
            data_q   <= data_d;
            closed_q <= closed_d;
        end
    end

    assign rdEn      = en_q;
    assign usrValid  = valid_q;
    assign usrData   = data_q;
    assign usrClosed = closed_q;

    a_rd_sample_first: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(en_q) |-> valid_q && data_q == $past(rdData))
        else $error("read enable raised without sampled word");
    a_rd_single_word: assert property (@(posedge mclk) disable iff (!rst_b)
        en_q |=> !en_q)
        else $error("read enable held past one word");
endmodule // sch_reader

// >>> stream_channel_handshake_tb_top.sv
// Self-checking bench for the stream channel host controller
`timescale 1ns/1ps
module stream_channel_handshake_tb_top;
    localparam int DEPTH = 4;
    logic                       mclk, rst_b, slow, chanRst;
    logic                       wrEn, wrEos, wrRdy, rdEn, rdRdy, rdEos;
    logic                       pinRdy, pinEos, pinEn, poutRdy, poutEn, poutEos;
    logic                       usrWrGo, usrWrClose, usrWrIdle, usrWrDone;
    logic                       usrRdWant, usrRdValid, usrRdClosed;
    logic                       usrSrcGo, usrSrcClose, usrSrcIdle;
    logic                       usrSnkEnable, usrSnkValid, usrSnkEos;
    logic [sch_pkg::DATA_W-1:0] wrData, rdData, pinData, poutData;
    logic [sch_pkg::DATA_W-1:0] usrWrData, usrRdData, usrSrcData, usrSnkData;
    logic [7:0]                 wq[$];
    logic [7:0]                 sq[$];
    int                         num_errors = 0;
    int                         total_checks = 0;
    bit                         snkClosed = 1'b0;
    bit                         rnd = 1'b0;
    bit                         wantFix = 1'b0;
    int                         doneCnt = 0;
    logic [7:0]                 lastW = 8'h00;

    sch_host dut (.mclk(mclk), .rst_b(rst_b), .chanRst(chanRst),
        .wrEn(wrEn), .wrEos(wrEos), .wrData(wrData), .wrRdy(wrRdy),
        .rdEn(rdEn), .rdRdy(rdRdy), .rdEos(rdEos), .rdData(rdData),
        .pinRdy(pinRdy), .pinEos(pinEos), .pinData(pinData), .pinEn(pinEn),
        .poutRdy(poutRdy), .poutEn(poutEn), .poutEos(poutEos), .poutData(poutData),
        .usrWrGo(usrWrGo), .usrWrClose(usrWrClose), .usrWrData(usrWrData),
        .usrWrIdle(usrWrIdle), .usrWrDone(usrWrDone), .usrRdWant(usrRdWant),
        .usrRdValid(usrRdValid), .usrRdData(usrRdData), .usrRdClosed(usrRdClosed),
        .usrSrcGo(usrSrcGo), .usrSrcClose(usrSrcClose), .usrSrcData(usrSrcData),
        .usrSrcIdle(usrSrcIdle), .usrSnkEnable(usrSnkEnable),
        .usrSnkValid(usrSnkValid), .usrSnkEos(usrSnkEos), .usrSnkData(usrSnkData));

    sch_chan_model #(.DEPTH(DEPTH)) partner (.mclk(mclk), .chanRst(chanRst), .slow(slow),
        .wrEn(wrEn), .wrEos(wrEos), .wrData(wrData), .wrRdy(wrRdy),
        .rdEn(rdEn), .rdRdy(rdRdy), .rdEos(rdEos), .rdData(rdData),
        .pinRdy(pinRdy), .pinEos(pinEos), .pinData(pinData), .pinEn(pinEn),
        .poutRdy(poutRdy), .poutEn(poutEn), .poutEos(poutEos), .poutData(poutData));

    // Clock at 25 MHz
    always #20 mclk = ~mclk;

    // Random stall of the partner and random reader demand
    always @(negedge mclk)
    begin
        slow      = rnd ? 1'($urandom) : 1'b0;
        usrRdWant = rnd ? 1'($urandom) : wantFix;
    end

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Oldest expected word, unknown when none is due
    function automatic logic [7:0] pop_exp(ref logic [7:0] q[$]);
        if (q.size() == 0)
            return 8'hXX;
        return q.pop_front();
    endfunction

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One write command through the writer engine
    task automatic wr(input logic [7:0] d, input logic c);
        while (usrWrIdle !== 1'b1) @(negedge mclk);
        usrWrGo = 1'b1;
        usrWrData = d;
        usrWrClose = c;
        if (!c)
        begin
            wq.push_back(d);
            lastW = d;
        end
        @(negedge mclk);
        usrWrGo = 1'b0;
    endtask

    // One word through the direct source
    task automatic src(input logic [7:0] d);
        while (usrSrcIdle !== 1'b1) @(negedge mclk);
        usrSrcGo = 1'b1;
        usrSrcData = d;
        sq.push_back(d);
        @(negedge mclk);
        usrSrcGo = 1'b0;
    endtask

    // Read and sink monitors
    always @(negedge mclk)
    begin
        if (usrWrDone === 1'b1)
            doneCnt++;
        if (usrRdValid === 1'b1)
            chk(usrRdData, pop_exp(wq));
        if (usrSnkValid === 1'b1 && usrSnkEos === 1'b1)
            snkClosed = 1'b1;
        else if (usrSnkValid === 1'b1)
            chk(usrSnkData, pop_exp(sq));
    end

    // Watchdog against a hang
    initial
    begin
        #(40 * 30000);
        num_errors++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        {mclk, rst_b, slow, usrWrGo, usrWrClose} = 5'h00;
        {usrSrcGo, usrSrcClose, usrSnkEnable} = 3'h0;
        usrWrData = 8'h00;
        usrSrcData = 8'h00;
        void'($urandom(1584));
        repeat (4) @(negedge mclk);
        chk(chanRst, 1'b1);
        chk({wrEn, wrEos, usrWrIdle, usrSrcIdle}, 4'h1);
        rst_b = 1'b1;
        repeat (2) @(negedge mclk);
        $display("test reset done");
        for (int i = 0; i <= DEPTH; i++)
            wr(8'($urandom), 1'b0);
        repeat (4) @(negedge mclk);
        chk({wrEn, wrRdy, rdRdy, rdEos}, 4'hA);
        wantFix = 1'b1;
        repeat (100) if (wq.size() != 0) @(negedge mclk);
        chk(8'(wq.size()), 8'h00);
        $display("test fill done");
        rnd = 1'b1;
        for (int i = 0; i < 30; i++)
            wr((i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom), 1'b0);
        rnd = 1'b0;
        repeat (200) if (wq.size() != 0) @(negedge mclk);
        chk(8'(wq.size()), 8'h00);
        $display("test random write done");
        wr(8'h5A, 1'b1);
        repeat (6) @(negedge mclk);
        chk({wrEos, rdEos, usrRdClosed}, 3'h7);
        chk(wrData, lastW);
        chk(8'(doneCnt), 8'h24);
        usrWrGo = 1'b1;
        @(negedge mclk);
        usrWrGo = 1'b0;
        repeat (3) @(negedge mclk);
        chk(wrEn, 1'b0);
        $display("test close done");
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        chk({chanRst, rdEos, usrRdClosed, wrEos}, 4'h8);
        rst_b = 1'b1;
        repeat (2) @(negedge mclk);
        wr(8'hA5, 1'b0);
        repeat (6) @(negedge mclk);
        chk(8'(wq.size()), 8'h00);
        $display("test mid reset done");
        usrSnkEnable = 1'b1;
        rnd = 1'b1;
        for (int i = 0; i < 30; i++)
            src((i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom));
        rnd = 1'b0;
        while (usrSrcIdle !== 1'b1) @(negedge mclk);
        usrSrcClose = 1'b1;
        @(negedge mclk);
        usrSrcClose = 1'b0;
        repeat (100) if (!snkClosed) @(negedge mclk);
        chk(snkClosed, 1'b1);
        chk(8'(sq.size()), 8'h00);
        $display("test direct link done");
        end_of_test();
    end
endmodule // stream_channel_handshake_tb_top
